// ===== csl_regs.svh
// Purpose: constants of the configuration stream loader
// Assumes: reference clock of 100 MHz; rates are held in kHz
// Notes:   mode code for parallel load is a local choice
//
// Overview of operation
// - master serial samples data each clock rise
// - in master serial, after own load, forward stream to chain
// - internal clock starts slow, only speeds up
// - selected clock rate capped at 60 MHz
// - 2.5 MHz until rate setting arrives
// - zero setting selects default 4 MHz
// - mode pins 000 or 100 select master serial
// - busy high; controller holds byte until low
// - selected and not writing drives readback
// - lane bit order reversed, MSB on bit 0
// - done goes high when loading finished
// - direction change under select aborts packet
// - busy held until aborted operation completes
// - after abort, hunt for fresh sync word
// - abort begins at next rising clock edge, or once the request under way is answered
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH

`define CSL_REF_KHZ     18'h186A0 // 100 MHz reference
`define CSL_WRAP_KHZ    (`CSL_REF_KHZ >> 1)
`define CSL_INIT_KHZ    18'h009C4 // 2.5 MHz
`define CSL_DEF_KHZ     18'h00FA0 // 4 MHz
`define CSL_MAX_KHZ     18'h0EA60 // 60 MHz
`define CSL_MAX_MHZ     8'h3C
`define CSL_KHZ_PER_MHZ 18'h003E8
`define CSL_MODE_MS_A   3'h0
`define CSL_MODE_MS_B   3'h4
`define CSL_MODE_PAR    3'h6
`define CSL_STRAP_AT    2'h2
`define CSL_STRAP_END   2'h3

`endif

// ===== csl_pkg.sv
// Purpose: types shared by the loader files
// Assumes: nothing
// Notes:   request word crosses from link clock to reference clock
package csl_pkg;
	typedef enum logic [1:0] {
		CSL_HUNT = 2'b00,
		CSL_RATE = 2'b01,
		CSL_LOAD = 2'b10,
		CSL_DONE = 2'b11
	} csl_load_st_t;

	typedef enum logic {
		CSL_IDLE = 1'b0,
		CSL_WAIT = 1'b1
	} csl_link_st_t;

	typedef enum logic [1:0] {
		CSL_WR = 2'b00,
		CSL_RD = 2'b01,
		CSL_AB = 2'b10
	} csl_kind_t;

	typedef struct packed {
		csl_kind_t  kind;
		logic [7:0] data;
	} csl_req_t;
endpackage : csl_pkg

// ===== csl_mem.sv
// Purpose: configuration byte store with registered read
// Assumes: one clock for both ports
// Notes:   contents are not reset, only the read register
module csl_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	input  wire logic             i_we,
	input  wire logic [AW-1:0]    i_waddr,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic             i_re,
	input  wire logic [AW-1:0]    i_raddr,
	output logic      [WIDTH-1:0] o_rdata
);
	if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_param
		$error("csl_mem: DEPTH does not fit AW");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];

	// write port
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	// read data leaves through a register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= '0;
		end else if (i_re) begin
			o_rdata <= mem_q[i_raddr];
		end
	end
endmodule : csl_mem

// ===== csl_loader.sv
`include "csl_regs.svh"
// Purpose: configuration loader, master serial and byte-wide parallel load
// Assumes: parallel port signals are synchronous to i_config_clock
// Notes:   parser and store run on i_ref_clk; the parallel port hands each
//          request over by a toggle handshake, and busy covers the crossing
module csl_loader #(
	parameter int                SYNC_W    = 32,
	parameter logic [SYNC_W-1:0] SYNC_WORD = 32'h5A3C_C35A, // arbitrary value
	parameter int                LOAD_LEN  = 64
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_config_clock,
	input  wire logic [2:0] i_mode_select_pins,
	input  wire logic       i_serial_data,
	input  wire logic       i_select_n,
	input  wire logic       i_write_n,
	input  wire logic [7:0] i_config_byte_lane,
	output logic            o_serial_out,
	output logic            o_config_clock,
	output logic            o_config_clock_oe,
	output logic [7:0]      o_config_byte_lane,
	output logic            o_config_byte_lane_oe,
	output logic            o_busy,
	output logic            o_config_done
);
	localparam int            AW   = (LOAD_LEN > 1) ? $clog2(LOAD_LEN) : 1;
	localparam logic [AW-1:0] LAST = AW'(LOAD_LEN - 1);

	if (SYNC_W < 16 || SYNC_W % 8 != 0 || LOAD_LEN < 2) begin : g_bad_param
		$error("csl_loader: SYNC_W must be a multiple of 8 from 16, LOAD_LEN from 2");
	end

	// reference clock domain
	logic [2:0]              mode_s1_q, mode_s2_q;
	logic [1:0]              strap_cnt_q;
	logic                    master_q, par_q;
	logic                    ser_s1_q, ser_s2_q;
	logic [17:0]             acc_q, acc_sum, rate_khz_q, rate_req;
	logic [7:0]              rate_mhz;
	logic                    config_clock_q, tick, ser_take;
	logic                    rq_s1_q, rq_s2_q, rq_s3_q, ack_q, rd_pend_q;
	logic                    hs_new, par_wr, abort_take;
	csl_pkg::csl_load_st_t   ld_st_q;
	logic [SYNC_W-1:0]       sh_q, sh_d;
	logic [7:0]              byte_q, byte_d, mem_rdata, rb_q;
	logic [2:0]              nbits_q;
	logic                    take, full, mem_we, mem_re, done_q, ser_out_q;
	logic [AW-1:0]           waddr_q, raddr_q;
	// link clock domain
	csl_pkg::csl_req_t       req_q;
	csl_pkg::csl_link_st_t   lk_st_q;
	logic                    req_tgl_q, pm_s1_q, pm_s2_q, ak_s1_q, ak_s2_q;
	logic                    busy_q, dir_ok_q, dir_wr_q, ab_pend_q, lane_oe_q;
	logic [7:0]              lane_q, lane_rev, rb_rev;
	logic                    sel, flip;

	// mode pins pass two flops, then are caught once after reset release
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode_s1_q   <= 3'h0;
			mode_s2_q   <= 3'h0;
			strap_cnt_q <= 2'h0;
			master_q    <= 1'b0;
			par_q       <= 1'b0;
		end else begin
			mode_s1_q <= i_mode_select_pins;
			mode_s2_q <= mode_s1_q;
			if (strap_cnt_q != `CSL_STRAP_END) begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
			if (strap_cnt_q == `CSL_STRAP_AT) begin
				master_q <= (mode_s2_q == `CSL_MODE_MS_A) || (mode_s2_q == `CSL_MODE_MS_B);
				par_q    <= (mode_s2_q == `CSL_MODE_PAR);
			end
		end
	end

	// clock generator: phase accumulator avoids a divider per rate
	assign acc_sum  = acc_q + rate_khz_q;
	assign tick     = master_q && (acc_sum >= `CSL_WRAP_KHZ);
	assign ser_take = tick && !config_clock_q; // rising edge of the driven clock

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ser_s1_q <= 1'b0;
			ser_s2_q <= 1'b0;
			acc_q    <= 18'h00000;
			config_clock_q   <= 1'b0;
		end else begin
			ser_s1_q <= i_serial_data;
			ser_s2_q <= ser_s1_q;
			if (tick) begin
				acc_q  <= acc_sum - `CSL_WRAP_KHZ;
				config_clock_q <= !config_clock_q;
			end else if (master_q) begin
				acc_q <= acc_sum;
			end
		end
	end

	// rate byte: zero means default, capped, and never lowers the rate
	assign rate_mhz = (byte_d > `CSL_MAX_MHZ) ? `CSL_MAX_MHZ : byte_d;
	assign rate_req = (byte_d == 8'h00) ? `CSL_DEF_KHZ
		: {10'h000, rate_mhz} * `CSL_KHZ_PER_MHZ;

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rate_khz_q <= `CSL_INIT_KHZ;
		end else if (take && full && ld_st_q == csl_pkg::CSL_RATE && rate_req > rate_khz_q) begin
			rate_khz_q <= rate_req;
		end
	end

	// requests from the parallel port, seen after a two flop toggle sync
	assign hs_new     = rq_s2_q ^ rq_s3_q;
	assign par_wr     = hs_new && req_q.kind == csl_pkg::CSL_WR;
	assign abort_take = hs_new && req_q.kind == csl_pkg::CSL_AB;
	assign mem_re     = hs_new && req_q.kind == csl_pkg::CSL_RD;

	// one input path: serial bits or whole parallel bytes
	always_comb begin
		take = ser_take || par_wr;
		if (par_q) begin
			sh_d   = {sh_q[SYNC_W-9:0], req_q.data};
			byte_d = req_q.data;
			full   = 1'b1;
		end else begin
			sh_d   = {sh_q[SYNC_W-2:0], ser_s2_q};
			byte_d = {byte_q[6:0], ser_s2_q};
			full   = (nbits_q == 3'h7);
		end
	end

	assign mem_we = take && full && ld_st_q == csl_pkg::CSL_LOAD;

	// stream parser: hunt, rate byte, own load, then pass serial bits through
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ld_st_q   <= csl_pkg::CSL_HUNT;
			sh_q      <= '0;
			byte_q    <= 8'h00;
			nbits_q   <= 3'h0;
			waddr_q   <= '0;
			done_q    <= 1'b0;
			ser_out_q <= 1'b0;
		end else if (abort_take) begin
			ld_st_q <= csl_pkg::CSL_HUNT;
			sh_q    <= '0;
			nbits_q <= 3'h0;
		end else if (take) begin
			byte_q  <= byte_d;
			nbits_q <= nbits_q + 3'h1;
			case (ld_st_q)
				csl_pkg::CSL_HUNT: begin
					sh_q    <= sh_d;
					nbits_q <= 3'h0;
					if (sh_d == SYNC_WORD) begin
						ld_st_q <= csl_pkg::CSL_RATE;
					end
				end
				csl_pkg::CSL_RATE: begin
					if (full) begin
						ld_st_q <= csl_pkg::CSL_LOAD;
						waddr_q <= '0;
					end
				end
				csl_pkg::CSL_LOAD: begin
					if (full) begin
						waddr_q <= waddr_q + AW'(1);
						if (waddr_q == LAST) begin
							ld_st_q <= csl_pkg::CSL_DONE;
							done_q  <= 1'b1;
						end
					end
				end
				default: begin
					if (!par_q) begin
						ser_out_q <= ser_s2_q;
					end
				end
			endcase
		end
	end

	csl_mem #(
		.WIDTH (8),
		.DEPTH (LOAD_LEN),
		.AW    (AW)
	) u_mem (
		.i_clk     (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_we      (mem_we),
		.i_waddr   (waddr_q),
		.i_wdata   (byte_d),
		.i_re      (mem_re),
		.i_raddr   (raddr_q),
		.o_rdata   (mem_rdata)
	);

	// answer side of the handshake; reads answer a cycle later
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rq_s1_q   <= 1'b0;
			rq_s2_q   <= 1'b0;
			rq_s3_q   <= 1'b0;
			ack_q     <= 1'b0;
			rd_pend_q <= 1'b0;
			raddr_q   <= '0;
			rb_q      <= 8'h00;
		end else begin
			rq_s1_q   <= req_tgl_q;
			rq_s2_q   <= rq_s1_q;
			rq_s3_q   <= rq_s2_q;
			rd_pend_q <= mem_re;
			if (abort_take) begin
				raddr_q <= '0;
			end else if (mem_re) begin
				raddr_q <= (raddr_q == LAST) ? '0 : raddr_q + AW'(1);
			end
			if (rd_pend_q) begin
				rb_q  <= mem_rdata;
				ack_q <= !ack_q;
			end else if (hs_new && !mem_re) begin
				ack_q <= !ack_q;
			end
		end
	end

	assign o_config_clock    = config_clock_q;
	assign o_config_clock_oe = master_q;
	assign o_serial_out      = ser_out_q;
	assign o_config_done     = done_q;

	// parallel port on the link clock
	assign sel  = pm_s2_q && !i_select_n;
	assign flip = sel && dir_ok_q && (dir_wr_q == i_write_n); // direction turned under select

	// lane bits travel reversed in both directions
	for (genvar i = 0; i < 8; i++) begin : g_rev
		assign lane_rev[i] = i_config_byte_lane[7-i];
		assign rb_rev[i]   = rb_q[7-i];
	end

	// level and answer toggle crossing into the link clock
	always_ff @(posedge i_config_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pm_s1_q   <= 1'b0;
			pm_s2_q   <= 1'b0;
			ak_s1_q   <= 1'b0;
			ak_s2_q   <= 1'b0;
			lane_oe_q <= 1'b0;
		end else begin
			pm_s1_q   <= par_q;
			pm_s2_q   <= pm_s1_q;
			ak_s1_q   <= ack_q;
			ak_s2_q   <= ak_s1_q;
			lane_oe_q <= sel && i_write_n;
		end
	end

	// request state: take, wait for answer, chain an abort if one came
	always_ff @(posedge i_config_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lk_st_q   <= csl_pkg::CSL_IDLE;
			req_q     <= '0;
			req_tgl_q <= 1'b0;
			busy_q    <= 1'b0;
			dir_ok_q  <= 1'b0;
			dir_wr_q  <= 1'b0;
			ab_pend_q <= 1'b0;
			lane_q    <= 8'h00;
		end else begin
			if (!sel) begin
				dir_ok_q <= 1'b0;
			end
			case (lk_st_q)
				csl_pkg::CSL_IDLE: begin
					if (sel) begin
						busy_q    <= 1'b1;
						lk_st_q   <= csl_pkg::CSL_WAIT;
						req_tgl_q <= !req_tgl_q;
						dir_ok_q  <= 1'b1;
						dir_wr_q  <= !i_write_n;
						if (flip) begin
							req_q.kind <= csl_pkg::CSL_AB;
						end else if (!i_write_n) begin
							req_q.kind <= csl_pkg::CSL_WR;
							req_q.data <= lane_rev;
						end else begin
							req_q.kind <= csl_pkg::CSL_RD;
						end
					end
				end
				default: begin
					// an abort waits for the operation under way
					if (flip) begin
						ab_pend_q <= 1'b1;
						dir_wr_q  <= !i_write_n;
					end
					if (ak_s2_q == req_tgl_q) begin
						if (req_q.kind == csl_pkg::CSL_RD) begin
							lane_q <= rb_rev;
						end
						if (ab_pend_q || flip) begin
							req_q.kind <= csl_pkg::CSL_AB;
							req_tgl_q  <= !req_tgl_q;
							ab_pend_q  <= 1'b0;
						end else begin
							busy_q  <= 1'b0;
							lk_st_q <= csl_pkg::CSL_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign o_busy                = busy_q;
	assign o_config_byte_lane    = lane_q;
	assign o_config_byte_lane_oe = lane_oe_q;

	// checks
	property p_sample;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		(ser_take && ld_st_q == csl_pkg::CSL_HUNT) |=> (config_clock_q && sh_q[0] == $past(ser_s2_q));
	endproperty
	a_sample: assert property (p_sample) else $error("serial bit not taken at rise");
	property p_forward;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		(ser_take && ld_st_q == csl_pkg::CSL_DONE) |=> (o_serial_out == $past(ser_s2_q));
	endproperty
	a_forward: assert property (p_forward) else $error("chain bit not forwarded");
	property p_rate_up;
		@(posedge i_ref_clk) disable iff (!i_reset_n) rate_khz_q >= $past(rate_khz_q);
	endproperty
	a_rate_up: assert property (p_rate_up) else $error("clock rate lowered");
	property p_rate_cap;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		(rate_khz_q <= `CSL_MAX_KHZ) && (rate_khz_q >= `CSL_INIT_KHZ);
	endproperty
	a_rate_cap: assert property (p_rate_cap) else $error("clock rate out of range");
	property p_rate_cause;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		$changed(rate_khz_q) |-> $past(take && full && ld_st_q == csl_pkg::CSL_RATE);
	endproperty
	a_rate_cause: assert property (p_rate_cause) else $error("rate moved without setting");
	property p_rate_def;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		(take && full && ld_st_q == csl_pkg::CSL_RATE && byte_d == 8'h00)
		|=> (rate_khz_q >= `CSL_DEF_KHZ);
	endproperty
	a_rate_def: assert property (p_rate_def) else $error("default rate not applied");
	property p_mode;
		@(posedge i_ref_clk) disable iff (!i_reset_n) (strap_cnt_q == `CSL_STRAP_AT)
		|=> (master_q == ($past(mode_s2_q) == `CSL_MODE_MS_A || $past(mode_s2_q) == `CSL_MODE_MS_B));
	endproperty
	a_mode: assert property (p_mode) else $error("master serial mode misdecoded");
	property p_busy;
		@(posedge i_config_clock) disable iff (!i_reset_n)
		(lk_st_q == csl_pkg::CSL_IDLE && sel) |=> (o_busy && lk_st_q == csl_pkg::CSL_WAIT);
	endproperty
	a_busy: assert property (p_busy) else $error("busy not raised on take");
	property p_rb_oe;
		@(posedge i_config_clock) disable iff (!i_reset_n) (sel && i_write_n) |=> o_config_byte_lane_oe;
	endproperty
	a_rb_oe: assert property (p_rb_oe) else $error("readback lane not driven");
	property p_rev;
		@(posedge i_config_clock) disable iff (!i_reset_n)
		(lk_st_q == csl_pkg::CSL_WAIT && ak_s2_q == req_tgl_q && req_q.kind == csl_pkg::CSL_RD)
		|=> (o_config_byte_lane[0] == $past(rb_q[7]) && o_config_byte_lane[7] == $past(rb_q[0]));
	endproperty
	a_rev: assert property (p_rev) else $error("readback bit order wrong");
	property p_done;
		@(posedge i_ref_clk) disable iff (!i_reset_n) $rose(o_config_done) |-> $past(mem_we && waddr_q == LAST);
	endproperty
	a_done: assert property (p_done) else $error("done without last byte");
	property p_abort;
		@(posedge i_config_clock) disable iff (!i_reset_n)
		(lk_st_q == csl_pkg::CSL_IDLE && flip) |=> (req_q.kind == csl_pkg::CSL_AB && o_busy [*2]);
	endproperty
	a_abort: assert property (p_abort) else $error("abort not started or busy dropped");
	property p_hunt;
		@(posedge i_ref_clk) disable iff (!i_reset_n) abort_take |=> (ld_st_q == csl_pkg::CSL_HUNT);
	endproperty
	a_hunt: assert property (p_hunt) else $error("abort left parser aligned");
	property p_sync;
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		(ld_st_q == csl_pkg::CSL_RATE && $past(ld_st_q) == csl_pkg::CSL_HUNT) |-> (sh_q == SYNC_WORD);
	endproperty
	a_sync: assert property (p_sync) else $error("aligned without sync word");

	c_ser_done: cover property (@(posedge i_ref_clk) $rose(done_q) && master_q);
	c_rate_up: cover property (@(posedge i_ref_clk) $changed(rate_khz_q));
	c_par_abort: cover property (@(posedge i_config_clock) lk_st_q == csl_pkg::CSL_IDLE && flip);
	c_readback: cover property (@(posedge i_config_clock) o_config_byte_lane_oe && !o_busy);
endmodule : csl_loader

// ===== csl_sermem_model.sv
// Purpose: serial configuration memory model for master serial loads
// Assumes: bit list and its length are set before the loader is put into reset and started again
// Notes:   past the end of the list the data line toggles so it never looks held
module csl_sermem_model (
	input  wire logic         i_clk,
	input  wire logic         i_start,
	input  wire logic [127:0] i_bits,
	input  wire logic [7:0]   i_len,
	output logic              o_data
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] idx_q;

	// advance on the fall, so the bit is settled well before the sampling rise
	always_ff @(negedge i_clk or posedge i_start) begin
		if (i_start) begin
			idx_q <= 8'h00;
		end else begin
			idx_q <= idx_q + 8'h01;
		end
	end

	// one bit per clock period, held across the rise
	assign o_data = (idx_q < i_len) ? i_bits[idx_q] : idx_q[0];
endmodule : csl_sermem_model

// ===== test_config_stream_loader.sv
// Purpose: self-checking bench of the loader, both modes
// Assumes: small sync word and load length set at the instance
// Notes:   readback and chain bits are noted in queues and checked by monitors
module test_config_stream_loader;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [15:0] SYNC = 16'hA5C3;
	localparam int          LOAD = 4;

	logic         i_ref_clk = 1'b0;
	logic         i_config_clock = 1'b0;
	logic         i_reset_n = 1'b0;
	logic [2:0]   strap = 3'h0;
	logic         sel_n = 1'b1;
	logic         wr_n = 1'b1;
	logic [7:0]   ctl_lane = 8'h00;
	logic         ctl_drv = 1'b0;
	logic         start = 1'b1;
	logic [127:0] sbits = '0;
	logic [7:0]   slen = 8'h00;
	logic         ser_data, ser_out, cfg_clk, cfg_clk_oe, lane_oe, busy, done, busy_was;
	logic [7:0]   lane_out, lane_w, pb [LOAD];
	logic [31:0]  xs = 32'h6A83;
	logic         chain_on = 1'b0;
	logic [7:0]   rdq [$];
	logic         chq [$];
	int           miscompares = 0;
	int           checked = 0;

	always #5 i_ref_clk = ~i_ref_clk;
	// link clock, phase offset from the reference, free running
	initial begin
		#1.7;
		forever #62.5 i_config_clock = ~i_config_clock;
	end
	// shared lane: device, controller, else inverse of ctl_lane
	assign lane_w = lane_oe ? lane_out : (ctl_drv ? ctl_lane : ~ctl_lane);

	csl_loader #(.SYNC_W(16), .SYNC_WORD(SYNC), .LOAD_LEN(LOAD)) DUT (
		.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_config_clock(i_config_clock),
		.i_mode_select_pins(strap), .i_serial_data(ser_data), .i_select_n(sel_n),
		.i_write_n(wr_n), .i_config_byte_lane(lane_w), .o_serial_out(ser_out),
		.o_config_clock(cfg_clk), .o_config_clock_oe(cfg_clk_oe),
		.o_config_byte_lane(lane_out), .o_config_byte_lane_oe(lane_oe),
		.o_busy(busy), .o_config_done(done));

	csl_sermem_model mem (.i_clk(cfg_clk), .i_start(start), .i_bits(sbits),
		.i_len(slen), .o_data(ser_data));

	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
	endfunction : rev8

	function automatic logic [7:0] rnd8();
		xs ^= xs << 13;
		xs ^= xs >> 17;
		xs ^= xs << 5;
		return xs[7:0];
	endfunction : rnd8

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
			miscompares++;
		end
	endtask : check

	task results();
		if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results

	task fail_to();
		miscompares++;
		results();
	endtask : fail_to

	// readback answer: busy drops while the device drives the lane
	always @(negedge i_config_clock) begin
		busy_was <= busy;
		if (busy_was === 1'b1 && busy === 1'b0 && lane_oe === 1'b1 && rdq.size() > 0)
			check("readback byte", lane_out, rdq.pop_front());
	end

	// forwarded chain bits, looked at while the driven clock is low
	always @(negedge cfg_clk) begin
		if (chain_on && chq.size() > 0) check("chain bit", ser_out, chq.pop_front());
	end

	task do_reset(input logic [2:0] m, input int n);
		@(negedge i_ref_clk);
		i_reset_n = 1'b0;
		start = 1'b1;
		strap = m;
		repeat (n) @(negedge i_ref_clk);
		i_reset_n = 1'b1;
		start = 1'b0;
	endtask : do_reset

	task put(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			sbits[slen] = v[i];
			slen = slen + 8'h01;
		end
	endtask : put

	// ref cycles from the previous rise of the driven clock to the next
	task wait_rise(output int cyc);
		logic p;
		p = cfg_clk;
		cyc = 0;
		forever begin
			@(negedge i_ref_clk);
			cyc++;
			if (cyc > 400) fail_to();
			if (p === 1'b0 && cfg_clk === 1'b1) break;
			p = cfg_clk;
		end
	endtask : wait_rise

	task serial_run(input logic [2:0] m, input logic [7:0] rate, input int exp_cyc);
		int cyc, s0, s1;
		logic [7:0] v;
		slen = 8'h00;
		put(8'hFF); // noise ahead of the sync word
		put(SYNC[15:8]);
		put(SYNC[7:0]);
		put(rate);
		repeat (LOAD) put(rnd8());
		v = rnd8();
		put(v);
		for (int i = 7; i >= 0; i--) chq.push_back(v[i]);
		do_reset(m, 26);
		s0 = 0;
		s1 = 0;
		for (int r = 1; r <= 73; r++) begin
			wait_rise(cyc);
			if (r >= 9 && r <= 12) s0 += cyc;
			if (r >= 41 && r <= 44) s1 += cyc;
			if (r == 63) begin
				check("done early", done, 1'b0);
				check("forward early", ser_out, 1'b0);
			end
			if (r == 65) begin
				check("done serial", done, 1'b1);
				chain_on = 1'b1;
			end
		end
		chain_on = 1'b0;
		check("start rate cycles", s0, 160);
		check("set rate cycles", s1, exp_cyc);
		check("chain left", chq.size(), 0);
	endtask : serial_run

	task wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0) begin
			@(negedge i_config_clock);
			n++;
			if (n > 8) fail_to();
		end
	endtask : wait_idle

	// one request, held until busy is low again
	// busy is honoured even though this link runs below 50 MHz
	task preq(input logic wr, input logic [7:0] b);
		sel_n = 1'b0; // only this device selected
		wr_n = ~wr;
		ctl_lane = rev8(b); // byte msb on lane bit 0
		ctl_drv = wr;
		@(negedge i_config_clock);
		check("busy after take", busy, 1'b1);
		wait_idle();
	endtask : preq

	// write strobe is left as it is across the deselect
	task desel();
		sel_n = 1'b1;
		ctl_drv = 1'b0;
		repeat (2) @(negedge i_config_clock);
	endtask : desel

	task par_start();
		do_reset(3'h6, 26);
		repeat (6) @(negedge i_config_clock);
		check("clock drive off", cfg_clk_oe, 1'b0);
		preq(1'b1, 8'hFF); // ignored before sync
		preq(1'b1, SYNC[15:8]);
		preq(1'b1, SYNC[7:0]);
		preq(1'b1, 8'hFF); // rate byte above the cap
	endtask : par_start

	initial begin
		do_reset(3'h0, 3);
		serial_run(3'h0, 8'h00, 100);
		serial_run(3'h4, 8'h10, 25);
		serial_run(3'h0, 8'h02, 160); // lower setting refused
		do_reset(3'h2, 26);
		repeat (40) @(negedge i_ref_clk);
		check("no serial mode", cfg_clk_oe, 1'b0);
		par_start();
		for (int i = 0; i < LOAD; i++) begin
			pb[i] = rnd8();
			preq(1'b1, pb[i]);
		end
		preq(1'b1, 8'h5E);
		desel();
		check("done parallel", done, 1'b1);
		for (int i = 0; i <= LOAD; i++) begin
			rdq.push_back(rev8(pb[i % LOAD]));
			preq(1'b0, 8'h00);
		end
		desel();
		check("lane released", lane_oe, 1'b0);
		check("reads left", rdq.size(), 0);
		par_start();
		pb[0] = rnd8();
		preq(1'b1, pb[0]);
		preq(1'b1, rnd8());
		wr_n = 1'b1; // direction change under one select
		@(negedge i_config_clock);
		check("busy in abort", busy, 1'b1);
		wait_idle();
		desel();
		rdq.push_back(rev8(pb[0]));
		preq(1'b0, 8'h00); // pointer back at zero
		// select still low, so a second read is taken at the next edge
		@(negedge i_config_clock);
		wr_n = 1'b0; // direction turned while that read is busy
		repeat (4) @(negedge i_config_clock);
		check("busy held past read", busy, 1'b1);
		wait_idle();
		desel();
		rdq.push_back(rev8(pb[0]));
		preq(1'b0, 8'h00); // abort has reset the pointer
		desel();
		repeat (4) preq(1'b1, 8'h11);
		desel();
		check("done without sync", done, 1'b0);
		preq(1'b1, SYNC[15:8]); // fresh sync first
		preq(1'b1, SYNC[7:0]);
		repeat (LOAD + 1) preq(1'b1, rnd8());
		desel();
		check("done after sync", done, 1'b1);
		check("reads left", rdq.size(), 0);
		results();
	end
endmodule : test_config_stream_loader
